// [hdl/emc_port.sv]
// external memory port: registers, space decode, on-chip ram, pin routing
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module emc_port
    import emc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mv_valid,
    output logic mv_ready,
    input wire logic mv_short,
    input wire logic mv_we,
    input wire logic [15:0] mv_addr,
    input wire logic [7:0] mv_wdata,
    output logic mv_done,
    output logic [7:0] mv_rdata,
    input wire logic [31:0] pin_lo_in,
    output logic [31:0] pin_lo_out,
    output logic [31:0] pin_lo_oe_n,
    input wire logic [31:0] pin_hi_in,
    output logic [31:0] pin_hi_out,
    output logic [31:0] pin_hi_oe_n,
    output logic own_lo,
    output logic own_hi
);
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] cfg;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic busy;
        logic on_pend;
        logic off_pend;
        logic last_off;
        logic go;
        logic we;
        logic drive_hi;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic done;
        logic [7:0] mrdata;
    } emc_port_s;

    emc_port_s r;
    emc_port_s next_r;
    emc_if sif ();
    logic [7:0] external_data_ram [0:RAM_WORDS-1];
    logic [7:0] ram_q;
    logic [15:0] eff;
    logic [1:0] mode;
    logic off;
    logic hi;
    logic ram_we;
    logic [RAM_AW-1:0] ram_idx;
    logic [31:0] bus_out;
    logic [31:0] bus_oe_n;

    // ---------------------------------------------------------------
    // address space decode
    // ---------------------------------------------------------------
    always_comb begin
        mode = r.cfg[CFG_MODE_HI:CFG_MODE_LO];
        eff = mv_short ? {r.page, mv_addr[7:0]} : mv_addr;
        off = 1'b0;
        hi = 1'b1;
        case (mode)
            MODE_ONCHIP: begin
                off = 1'b0;
            end
            MODE_SPLIT: begin
                off = (eff >= SPLIT_BOUND);
                hi = !mv_short;
            end
            MODE_BANK: begin
                off = (eff >= SPLIT_BOUND);
            end
            MODE_OFFCHIP: begin
                // short form ignores the page and leaves the high lane
                off = 1'b1;
                hi = !mv_short;
                eff = mv_short ? {8'h00, mv_addr[7:0]} : mv_addr;
            end
            default: begin
                off = 1'b0;
            end
        endcase
        ram_idx = eff[RAM_AW-1:0];
        ram_we = mv_valid && !r.busy && !off && mv_we;
    end

    assign mv_ready = !r.busy;

    // ---------------------------------------------------------------
    // register bus and move control
    // ---------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.go = 1'b0;
        next_r.done = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_r.aw_hold = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_r.w_hold = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (r.aw_hold && r.w_hold && !r.bvalid) begin
            next_r.aw_hold = 1'b0;
            next_r.w_hold = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = RESP_OKAY;
            case (r.aw_addr)
                OFS_PAGE: begin
                    if (r.w_strb[0]) begin
                        next_r.page = r.w_data[7:0];
                    end
                end
                OFS_CFG: begin
                    if (r.w_strb[0]) begin
                        next_r.cfg = r.w_data[7:0] & CFG_WMASK;
                    end
                end
                OFS_STAT: begin
                    next_r.bresp = RESP_OKAY;
                end
                default: begin
                    next_r.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = RESP_OKAY;
            next_r.rdata = '0;
            case (s_axi_araddr)
                OFS_PAGE: begin
                    next_r.rdata[7:0] = r.page;
                end
                OFS_CFG: begin
                    next_r.rdata[7:0] = r.cfg;
                end
                OFS_STAT: begin
                    next_r.rdata[STAT_BUSY] = r.busy;
                    next_r.rdata[STAT_OFF] = r.last_off;
                end
                default: begin
                    next_r.rresp = RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (mv_valid && !r.busy) begin
            next_r.busy = 1'b1;
            next_r.last_off = off;
            next_r.on_pend = !off;
            next_r.off_pend = off;
            next_r.go = off;
            next_r.we = mv_we;
            next_r.drive_hi = hi;
            next_r.addr = eff;
            next_r.wdata = mv_wdata;
        end
        if (r.on_pend) begin
            next_r.on_pend = 1'b0;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.mrdata = r.we ? r.mrdata : ram_q;
        end
        if (r.off_pend && sif.done) begin
            next_r.off_pend = 1'b0;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            next_r.mrdata = r.we ? r.mrdata : sif.rdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '{page: RST_PAGE, cfg: RST_CFG, default: '0};
        end else if (ce) begin
            r <= next_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (ce) begin
            if (ram_we) begin
                external_data_ram[ram_idx] <= mv_wdata;
            end
            ram_q <= external_data_ram[ram_idx];
        end
    end

    assign s_axi_awready = !r.aw_hold && !r.bvalid;
    assign s_axi_wready = !r.w_hold && !r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;
    assign mv_done = r.done;
    assign mv_rdata = r.mrdata;

    // ---------------------------------------------------------------
    // sequencer and pin routing
    // ---------------------------------------------------------------
    assign sif.go = r.go;
    assign sif.we = r.we;
    assign sif.drive_hi = r.drive_hi;
    assign sif.addr = r.addr;
    assign sif.wdata = r.wdata;
    assign sif.mux = !r.cfg[CFG_MUX];
    assign sif.ale_w = r.cfg[CFG_ALE_HI:CFG_ALE_LO];
    assign sif.din = r.cfg[CFG_GRP] ? pin_hi_in[LANE_AD+:8]
                                    : pin_lo_in[LANE_AD+:8];

    emc_seq emc_seq_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .bus(sif.seq)
    );

    always_comb begin
        bus_out = '0;
        bus_oe_n = ALL_OFF;
        bus_out[PIN_WR] = sif.wr_n;
        bus_out[PIN_RD] = sif.rd_n;
        bus_out[PIN_ALE] = sif.ale;
        bus_out[LANE_AD+:8] = sif.ad_out;
        bus_out[LANE_AHI+:8] = sif.a_out[15:8];
        bus_out[LANE_ALO+:8] = sif.a_out[7:0];
        if (sif.busy) begin
            bus_oe_n[PIN_WR] = 1'b0;
            bus_oe_n[PIN_RD] = 1'b0;
            bus_oe_n[PIN_ALE] = !sif.ale_en;
            bus_oe_n[LANE_AD+:8] = {8{!sif.ad_en}};
            bus_oe_n[LANE_AHI+:8] = {8{!sif.ahi_en}};
            bus_oe_n[LANE_ALO+:8] = {8{!sif.alo_en}};
        end
    end

    // only enables leave here; drive strength stays with the port mode
    // registers outside
    assign own_lo = sif.busy && !r.cfg[CFG_GRP];
    assign own_hi = sif.busy && r.cfg[CFG_GRP];
    assign pin_lo_out = own_lo ? bus_out : '0;
    assign pin_hi_out = own_hi ? bus_out : '0;
    assign pin_lo_oe_n = own_lo ? bus_oe_n : ALL_OFF;
    assign pin_hi_oe_n = own_hi ? bus_oe_n : ALL_OFF;
endmodule : emc_port

// [hdl/emc_pkg.sv]
// constants, register map and field layout for the external memory port
package emc_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_PAGE = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h03;
    localparam logic [7:0] CFG_WMASK = 8'h3F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ---------------------------------------------------------------
    // config fields
    // ---------------------------------------------------------------
    localparam int CFG_GRP = 5;
    localparam int CFG_MUX = 4;
    localparam int CFG_MODE_HI = 3;
    localparam int CFG_MODE_LO = 2;
    localparam int CFG_ALE_HI = 1;
    localparam int CFG_ALE_LO = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_OFF = 1;
    // ---------------------------------------------------------------
    // memory modes and address space
    // ---------------------------------------------------------------
    localparam logic [1:0] MODE_ONCHIP = 2'h0;
    localparam logic [1:0] MODE_SPLIT = 2'h1;
    localparam logic [1:0] MODE_BANK = 2'h2;
    localparam logic [1:0] MODE_OFFCHIP = 2'h3;
    localparam int RAM_AW = 12;
    localparam int RAM_WORDS = 4096;
    localparam logic [15:0] SPLIT_BOUND = 16'h1000;
    // ---------------------------------------------------------------
    // pin layout inside a four-port group
    // ---------------------------------------------------------------
    localparam int PIN_WR = 7;
    localparam int PIN_RD = 6;
    localparam int PIN_ALE = 5;
    localparam int LANE_AD = 8;
    localparam int LANE_AHI = 16;
    localparam int LANE_ALO = 24;
    localparam logic [31:0] ALL_OFF = 32'hFFFFFFFF;
    localparam logic [1:0] HOLD_CYCLES = 2'h0;
endpackage : emc_pkg

// [hdl/emc_if.sv]
// handshake and pin-phase signals between port logic and sequencer
`timescale 1ns/1ps
interface emc_if;
    logic go;
    logic we;
    logic drive_hi;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic mux;
    logic [1:0] ale_w;
    logic [7:0] din;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic ale_en;
    logic [7:0] ad_out;
    logic ad_en;
    logic alo_en;
    logic ahi_en;
    logic [15:0] a_out;
    modport ctl (output go, we, drive_hi, addr, wdata, mux, ale_w, din,
        input busy, done, rdata, ale, rd_n, wr_n, ale_en, ad_out, ad_en,
        alo_en, ahi_en, a_out);
    modport seq (input go, we, drive_hi, addr, wdata, mux, ale_w, din,
        output busy, done, rdata, ale, rd_n, wr_n, ale_en, ad_out, ad_en,
        alo_en, ahi_en, a_out);
endinterface : emc_if

// [hdl/emc_seq.sv]
// off-chip transfer sequencer: latch pulse, strobe, data sampling
`timescale 1ns/1ps
module emc_seq
    import emc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    emc_if.seq bus
);
    typedef enum logic [2:0] {SQ_IDLE, SQ_ALE, SQ_HOLD, SQ_STB, SQ_DONE}
        emc_sq_e;
    typedef struct packed {
        emc_sq_e st;
        logic [1:0] cnt;
        logic we;
        logic mux;
        logic drive_hi;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic [7:0] ad_out;
        logic ad_en;
        logic done;
        logic [7:0] rdata;
    } emc_sq_s;

    emc_sq_s r;
    emc_sq_s next_r;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        case (r.st)
            SQ_IDLE: begin
                if (bus.go) begin
                    next_r.we = bus.we;
                    next_r.mux = bus.mux;
                    next_r.drive_hi = bus.drive_hi;
                    next_r.addr = bus.addr;
                    next_r.wdata = bus.wdata;
                    next_r.ad_en = 1'b1;
                    if (bus.mux) begin
                        // ale high for code+1 cycles
                        next_r.st = SQ_ALE;
                        next_r.cnt = bus.ale_w;
                        next_r.ale = 1'b1;
                        next_r.ad_out = bus.addr[7:0];
                    end else begin
                        next_r.st = SQ_STB;
                        next_r.rd_n = bus.we;
                        next_r.wr_n = ~bus.we;
                        next_r.ad_out = bus.wdata;
                        next_r.ad_en = bus.we;
                    end
                end
            end
            SQ_ALE: begin
                if (r.cnt == HOLD_CYCLES) begin
                    next_r.st = SQ_HOLD;
                    next_r.ale = 1'b0;
                end else begin
                    next_r.cnt = r.cnt - 2'h1;
                end
            end
            SQ_HOLD: begin
                // address held on the shared lane one cycle past ale
                next_r.st = SQ_STB;
                next_r.rd_n = r.we;
                next_r.wr_n = ~r.we;
                next_r.ad_out = r.wdata;
                next_r.ad_en = r.we;
            end
            SQ_STB: begin
                next_r.st = SQ_DONE;
                next_r.rd_n = 1'b1;
                next_r.wr_n = 1'b1;
                next_r.ad_en = 1'b0;
                next_r.rdata = r.we ? r.rdata : bus.din;
            end
            SQ_DONE: begin
                next_r.st = SQ_IDLE;
                next_r.done = 1'b1;
            end
            default: begin
                next_r.st = SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '{st: SQ_IDLE, rd_n: 1'b1, wr_n: 1'b1, default: '0};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign bus.busy = (r.st != SQ_IDLE) && (r.st != SQ_DONE);
    assign bus.done = r.done;
    assign bus.rdata = r.rdata;
    assign bus.ale = r.ale;
    assign bus.rd_n = r.rd_n;
    assign bus.wr_n = r.wr_n;
    assign bus.ale_en = bus.busy && r.mux;
    assign bus.ad_out = r.ad_out;
    assign bus.ad_en = r.ad_en;
    assign bus.alo_en = bus.busy && !r.mux;
    assign bus.ahi_en = bus.busy && r.drive_hi;
    assign bus.a_out = r.addr;
endmodule : emc_seq

// [tb/emc_port_monitor.sv]
// assertion checker for the external memory port
`timescale 1ns/1ps
module emc_port_monitor
    import emc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic mv_valid,
    input wire logic mv_ready,
    input wire logic mv_done,
    input wire logic [31:0] pin_lo_out,
    input wire logic [31:0] pin_lo_oe_n,
    input wire logic own_lo,
    input wire logic own_hi
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !ce);

    a_one_group: assert property (!(own_lo && own_hi))
        else $error("both port groups owned at once");
    a_lo_idle: assert property (
        !own_lo |-> pin_lo_oe_n == ALL_OFF)
        else $error("lower group driven while not owned");
    a_read_released: assert property (!pin_lo_oe_n[PIN_RD] &&
        !pin_lo_out[PIN_RD] |-> pin_lo_oe_n[15:8] == 8'hFF)
        else $error("data lane driven during read strobe");
    a_write_driven: assert property (!pin_lo_oe_n[PIN_WR] &&
        !pin_lo_out[PIN_WR] |-> pin_lo_oe_n[15:8] == 8'h00)
        else $error("data lane released during write strobe");
    a_done_after_own: assert property (
        $fell(own_lo) |-> ##2 mv_done)
        else $error("move not finished after pins handed back");
    a_move_busy: assert property (mv_valid && mv_ready |=> !mv_ready)
        else $error("second move accepted while busy");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read response late");
endmodule : emc_port_monitor

bind emc_port emc_port_monitor emc_port_monitor_inst (.aclk, .aresetn, .ce,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .mv_valid, .mv_ready, .mv_done, .pin_lo_out, .pin_lo_oe_n,
    .own_lo, .own_hi);

// [tb/emc_sram_model.sv]
// off-chip byte-wide memory hanging on one four-port group
`timescale 1ns/1ps
module emc_sram_model (
    input wire logic aclk,
    input wire logic mux,
    input wire logic [31:0] pout,
    input wire logic [31:0] poe_n,
    output logic [31:0] pin
);
    localparam int PIN_RD_M = 6;
    logic [7:0] mem [0:65535];
    logic [7:0] alo;
    logic [7:0] prev = 8'h5A;
    logic [15:0] a;
    logic rd;
    logic wr;
    logic [7:0] dl;
    // released strobes read as parked high
    assign rd = !poe_n[PIN_RD_M] && !pout[PIN_RD_M];
    assign wr = !poe_n[7] && !pout[7];
    // released upper address lines read as pulled low
    assign a = {poe_n[16] ? 8'h00 : pout[23:16], mux ? alo : pout[31:24]};
    // data lane floats to a changing pattern when not read
    assign dl = rd ? mem[a] : ~prev;
    assign pin = {pout[31:16], dl, pout[7:0]};
    always_ff @(posedge aclk) begin
        prev <= dl;
        if (!poe_n[5] && pout[5])
            alo <= pout[15:8];
        if (wr)
            mem[a] <= pout[15:8];
    end
endmodule : emc_sram_model

// [tb/external_memory_port_config_bench.sv]
// self-checking bench for the external memory port
`timescale 1ns/1ps
module external_memory_port_config_bench
    import emc_pkg::*;
    ;
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] pg;
        logic sh;
        logic [15:0] wa;
        logic [15:0] ra;
        logic [15:0] ea;
        logic off;
        logic hi;
    } emc_row_s;
    localparam emc_row_s ROWS [7] = '{
        '{8'h03, 8'h00, 1'b0, 16'h0123, 16'h1123, 16'h0000, 1'b0, 1'b0},
        '{8'h1C, 8'h00, 1'b0, 16'h0045, 16'h0045, 16'h0045, 1'b1, 1'b0},
        '{8'h07, 8'h00, 1'b0, 16'h2345, 16'h2345, 16'h2345, 1'b1, 1'b0},
        '{8'h39, 8'h56, 1'b1, 16'h0078, 16'h0078, 16'h5678, 1'b1, 1'b1},
        '{8'h09, 8'h34, 1'b1, 16'h0012, 16'h0012, 16'h3412, 1'b1, 1'b0},
        '{8'h0E, 8'h77, 1'b1, 16'h009A, 16'h009A, 16'h009A, 1'b1, 1'b0},
        '{8'h04, 8'h20, 1'b1, 16'h0011, 16'h0011, 16'h0011, 1'b1, 1'b0}};
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, mv_valid, mv_short, mv_we, mv_ready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, mv_done, own_lo, own_hi, seen_lo, seen_hi;
    logic [7:0] s_axi_awaddr, s_axi_araddr, mv_wdata, mv_rdata, cfg, q, d;
    logic [31:0] s_axi_wdata, s_axi_rdata, pin_lo_in, pin_lo_out;
    logic [31:0] pin_lo_oe_n, pin_hi_in, pin_hi_out, pin_hi_oe_n, q32;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] mv_addr;
    emc_row_s r;
    int err_total, checked, cyc, ale_run, ale_max;

    emc_port emc_port_inst (.aclk, .aresetn, .ce, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mv_valid,
        .mv_ready, .mv_short, .mv_we, .mv_addr, .mv_wdata, .mv_done,
        .mv_rdata, .pin_lo_in, .pin_lo_out, .pin_lo_oe_n, .pin_hi_in,
        .pin_hi_out, .pin_hi_oe_n, .own_lo, .own_hi);
    emc_sram_model lo_mem (.aclk, .mux(!cfg[4]), .pout(pin_lo_out),
        .poe_n(pin_lo_oe_n), .pin(pin_lo_in));
    emc_sram_model hi_mem (.aclk, .mux(!cfg[4]), .pout(pin_hi_out),
        .poe_n(pin_hi_oe_n), .pin(pin_hi_in));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string w, input logic [31:0] e,
            input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] v);
        s_axi_awaddr <= ad;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] ad);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rs = s_axi_rresp;
        q32 = s_axi_rdata;
    endtask : axi_rd

    task automatic mv(input logic sh, input logic we, input logic [15:0] ad,
            input logic [7:0] v);
        mv_short <= sh;
        mv_we <= we;
        mv_addr <= ad;
        mv_wdata <= v;
        mv_valid <= 1'b1;
        do begin
            @(posedge aclk);
            if (mv_valid && mv_ready)
                mv_valid <= 1'b0;
        end while (mv_done !== 1'b1);
        q = mv_rdata;
    endtask : mv

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // cycle limit, pin ownership and latch pulse watch
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (own_lo)
            seen_lo = 1'b1;
        if (own_hi)
            seen_hi = 1'b1;
        ale_run = (pin_lo_out[PIN_ALE] || pin_hi_out[PIN_ALE]) ?
            ale_run + 1 : 0;
        if (ale_run > ale_max)
            ale_max = ale_run;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, mv_valid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mv_addr, mv_wdata} = '0;
        {mv_short, mv_we, err_total, checked, cyc, ale_run} = '0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        s_axi_wstrb = 4'hF;
        ce = 1'b1;
        cfg = 8'h03;
        aresetn = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(OFS_PAGE);
        chk("page reset", 32'h0, q32);
        axi_rd(OFS_CFG);
        chk("config reset", 32'h3, q32);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            cfg = r.cfg;
            axi_wr(OFS_PAGE, {24'h0, r.pg});
            axi_wr(OFS_CFG, {24'h0, r.cfg});
            d = 8'hA0 + 8'(i);
            seen_lo = 1'b0;
            seen_hi = 1'b0;
            ale_max = 0;
            mv(r.sh, 1'b1, r.wa, d);
            mv(r.sh, 1'b0, r.ra, 8'h00);
            chk("move read", {24'h0, d}, {24'h0, q});
            chk("lower owned", 32'(r.off && !r.hi),
                32'(seen_lo));
            chk("upper owned", 32'(r.off && r.hi),
                32'(seen_hi));
            chk("latch cycles", (r.cfg[4] || !r.off) ? 32'h0 :
                32'(r.cfg[1:0]) + 32'h1, 32'(ale_max));
            if (r.off)
                chk("far byte", {24'h0, d}, {24'h0, r.hi ?
                    hi_mem.mem[r.ea] : lo_mem.mem[r.ea]});
        end
        axi_rd(OFS_STAT);
        chk("status", 32'h2, q32);
        // ce low freezes a move request
        mv(1'b0, 1'b1, 16'h0200, 8'h11);
        ce <= 1'b0;
        mv_we <= 1'b1;
        mv_addr <= 16'h0200;
        mv_wdata <= 8'h5C;
        mv_valid <= 1'b1;
        repeat (4) @(posedge aclk);
        mv_valid <= 1'b0;
        ce <= 1'b1;
        @(posedge aclk);
        mv(1'b0, 1'b0, 16'h0200, 8'h00);
        chk("frozen move", 32'h11, {24'h0, q});
        axi_wr(OFS_CFG, 32'hFF);
        axi_rd(OFS_CFG);
        chk("config mask", 32'h3F, q32);
        axi_wr(8'h0C, 32'h1);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rs});
        axi_rd(8'h0C);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rs});
        axi_wr(OFS_STAT, 32'h3);
        chk("status write", {30'h0, RESP_OKAY}, {30'h0, rs});
        s_axi_wstrb <= 4'h0;
        axi_wr(OFS_PAGE, 32'h99);
        s_axi_wstrb <= 4'hF;
        axi_rd(OFS_PAGE);
        chk("page unstrobed", 32'h20, q32);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(OFS_CFG);
        chk("config rereset", 32'h3, q32);
        report_and_stop();
    end
endmodule : external_memory_port_config_bench
